/* logic/sfcef_pkg.sv */
// constants and types shared by the event flag block and its frame receiver
package sfcef_pkg;

  // serial frame geometry
  localparam int unsigned FRAME_BITS = 32;
  localparam int unsigned CNT_W      = 6;
  localparam logic [CNT_W-1:0] CNT_FULL = 6'h20;
  localparam logic [CNT_W-1:0] CNT_SAT  = 6'h21;
  localparam logic [CNT_W-1:0] CNT_NONE = 6'h00;

  // command word layout: write flag, address, data, parity
  localparam int unsigned CMD_WR_BIT  = 31;
  localparam int unsigned CMD_ADR_HI  = 30;
  localparam int unsigned CMD_ADR_LO  = 25;
  localparam int unsigned CMD_DAT_HI  = 24;
  localparam int unsigned CMD_DAT_LO  = 1;
  localparam int unsigned ADR_W       = 6;

  // register addresses
  localparam logic [ADR_W-1:0] ADR_EVENT_FLAGS = 6'h01;
  localparam logic [ADR_W-1:0] ADR_CONTROL     = 6'h1A;
  localparam int unsigned      CTRL_SOFT_RESET = 0;

  // status register and its flag positions
  localparam int unsigned REG_W       = 24;
  localparam int unsigned FLAG_RESET  = 0;
  localparam int unsigned FLAG_FRAME  = 1;
  localparam int unsigned FLAG_PARITY = 2;
  localparam int unsigned FLAG_SWITCH = 3;
  localparam int unsigned FLAG_THERM  = 4;
  localparam int unsigned FLAG_NUM    = 5;
  localparam logic [REG_W-1:0] FLAGS_DEFAULT = 24'h00_0001;

  localparam int unsigned SWITCH_NUM = 24;

  typedef logic [FRAME_BITS-1:0] sfcef_word_t;
  typedef logic [REG_W-1:0]      sfcef_reg_t;

endpackage

/* logic/sfcef_frame_if.sv */
// frame results passed from the serial receiver to the flag core
interface sfcef_frame_if;
  import sfcef_pkg::*;
  sfcef_word_t word;
  logic        word_valid;
  logic        length_error;
  logic        parity_error;
  logic        soft_reset;

  modport rx   (output word, output word_valid, output length_error, output parity_error, input soft_reset);
  modport core (input word, input word_valid, input length_error, input parity_error, output soft_reset);
endinterface

/* logic/sfcef_frame_rx.sv */
// serial frame receiver: bit count and odd parity check per chip-select period
module sfcef_frame_rx (
  input  wire logic    mclk,
  input  wire logic    resetn,
  input  wire logic    cs_n_pin,
  input  wire logic    sclk_pin,
  input  wire logic    sdi_pin,
  sfcef_frame_if.rx    frm
);

  import sfcef_pkg::*;

  logic [2:0]       cs_sync_q;
  logic [2:0]       sclk_sync_q;
  logic [1:0]       sdi_sync_q;
  logic [CNT_W-1:0] cnt_q;
  sfcef_word_t      shift_q;
  logic             cs_fall;
  logic             cs_rise;
  logic             sclk_rise;

  // stage 0 is read only by stage 1; edges use stages 1 and 2
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cs_sync_q   <= 3'h7;
      sclk_sync_q <= 3'h0;
      sdi_sync_q  <= 2'h0;
    end else begin
      cs_sync_q   <= {cs_sync_q[1:0], cs_n_pin};
      sclk_sync_q <= {sclk_sync_q[1:0], sclk_pin};
      sdi_sync_q  <= {sdi_sync_q[0], sdi_pin};
    end
  end

  assign cs_fall   = cs_sync_q[2] & ~cs_sync_q[1];
  assign cs_rise   = ~cs_sync_q[2] & cs_sync_q[1];
  assign sclk_rise = ~sclk_sync_q[2] & sclk_sync_q[1] & ~cs_sync_q[1];

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt_q   <= CNT_NONE;
      shift_q <= '0;
    end else if (frm.soft_reset || cs_fall) begin
      cnt_q   <= CNT_NONE;
      shift_q <= '0;
    end else if (sclk_rise) begin
      shift_q <= {shift_q[FRAME_BITS-2:0], sdi_sync_q[1]};
      // saturate so long frames never wrap back to 32
      if (cnt_q != CNT_SAT) begin
        cnt_q <= cnt_q + 6'h01;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      frm.word         <= '0;
      frm.word_valid   <= 1'b0;
      frm.length_error <= 1'b0;
      frm.parity_error <= 1'b0;
    end else begin
      frm.word_valid   <= 1'b0;
      frm.length_error <= 1'b0;
      frm.parity_error <= 1'b0;
      if (cs_rise && !frm.soft_reset) begin
        if (cnt_q == CNT_NONE) begin
          frm.length_error <= 1'b0;
        end else if (cnt_q != CNT_FULL) begin
          frm.length_error <= 1'b1;
        end else if (~^shift_q) begin
          frm.parity_error <= 1'b1;
        end else begin
          frm.word       <= shift_q;
          frm.word_valid <= 1'b1;
        end
      end
    end
  end

endmodule

/* logic/sfcef_event_flags.sv */
// event flag status register with clear-on-read and serial frame checks
module sfcef_event_flags (
  input  wire logic                             mclk,
  input  wire logic                             resetn,
  input  wire logic                             cs_n_pin,
  input  wire logic                             sclk_pin,
  input  wire logic                             sdi_pin,
  input  wire logic                             thermal_shutdown_pin,
  input  wire logic [sfcef_pkg::SWITCH_NUM-1:0] switch_inputs,
  input  wire logic                             polling_trigger,
  input  wire logic                             poll_cycle_done,
  output logic [sfcef_pkg::REG_W-1:0]           event_flags_status_q,
  output logic [sfcef_pkg::REG_W-1:0]           read_data_q,
  output logic                                  read_done_q,
  output logic [sfcef_pkg::FRAME_BITS-1:0]      cmd_word_q,
  output logic                                  cmd_valid_q,
  output logic                                  parity_status_copy_q,
  output logic                                  frame_status_copy_q,
  output logic                                  reset_status_copy_q
);

  import sfcef_pkg::*;

  sfcef_frame_if frm ();

  sfcef_frame_rx u_rx (
    .mclk     (mclk),
    .resetn   (resetn),
    .cs_n_pin (cs_n_pin),
    .sclk_pin (sclk_pin),
    .sdi_pin  (sdi_pin),
    .frm      (frm.rx)
  );

  function automatic logic [ADR_W-1:0] cmd_addr(input sfcef_word_t w);
    cmd_addr = w[CMD_ADR_HI:CMD_ADR_LO];
  endfunction

  function automatic logic cmd_is_write(input sfcef_word_t w);
    cmd_is_write = w[CMD_WR_BIT];
  endfunction

  logic [2:0]            therm_sync_q;
  logic [SWITCH_NUM-1:0] sw_sync0_q;
  logic [SWITCH_NUM-1:0] sw_sync1_q;
  logic [SWITCH_NUM-1:0] sw_prev_q;
  logic [2:0]            sw_prime_q;
  logic                  sw_change;
  logic                  poll_first_done;
  logic                  poll_armed_q;
  logic                  soft_reset_q;
  logic                  status_read;
  logic                  soft_reset_cmd;
  logic [FLAG_NUM-1:0]   set_vec;
  sfcef_reg_t            flags_d;

  // analog-side levels come in unsynchronised
  // two sync stages, the third only for edge compare
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      therm_sync_q <= 3'h0;
      sw_sync0_q   <= '0;
      sw_sync1_q   <= '0;
      sw_prev_q    <= '0;
    end else begin
      therm_sync_q <= {therm_sync_q[1:0], thermal_shutdown_pin};
      sw_sync0_q   <= switch_inputs;
      sw_sync1_q   <= sw_sync0_q;
      sw_prev_q    <= sw_sync1_q;
    end
  end

  // compares start once sw_prev_q holds a real sample, three edges in;
  // a switch change inside that window after a soft reset is not flagged
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sw_prime_q <= 3'h0;
    end else if (soft_reset_q) begin
      sw_prime_q <= 3'h0;
    end else begin
      sw_prime_q <= {sw_prime_q[1:0], 1'b1};
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      poll_armed_q <= 1'b0;
    end else if (soft_reset_q) begin
      poll_armed_q <= 1'b0;
    end else if (polling_trigger) begin
      poll_armed_q <= 1'b1;
    end else if (poll_cycle_done) begin
      poll_armed_q <= 1'b0;
    end
  end

  assign status_read    = frm.word_valid && !cmd_is_write(frm.word)
                          && cmd_addr(frm.word) == ADR_EVENT_FLAGS;
  assign soft_reset_cmd = frm.word_valid && cmd_is_write(frm.word) && cmd_addr(frm.word) == ADR_CONTROL
                          && frm.word[CMD_DAT_LO + CTRL_SOFT_RESET];

  assign sw_change       = sw_prime_q[2] && (sw_sync1_q != sw_prev_q);
  // first poll cycle after trigger; a trigger in the same cycle re-arms instead
  assign poll_first_done = poll_armed_q && poll_cycle_done && !polling_trigger;

  always_comb begin
    set_vec = '0;
    set_vec[FLAG_THERM]  = therm_sync_q[2] ^ therm_sync_q[1];
    set_vec[FLAG_SWITCH] = sw_change || poll_first_done;
    set_vec[FLAG_PARITY] = frm.parity_error;
    set_vec[FLAG_FRAME]  = frm.length_error;
    set_vec[FLAG_RESET]  = 1'b0;
  end

  always_comb begin
    flags_d = status_read ? '0 : event_flags_status_q;
    flags_d[FLAG_NUM-1:0] = flags_d[FLAG_NUM-1:0] | set_vec;
  end

  // soft reset is applied one cycle after its frame is accepted
  // so that frame's accept pulse still shows for one cycle
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      soft_reset_q <= 1'b0;
    end else begin
      soft_reset_q <= soft_reset_cmd;
    end
  end

  assign frm.soft_reset = soft_reset_q;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      event_flags_status_q <= FLAGS_DEFAULT;
    end else if (soft_reset_q) begin
      event_flags_status_q <= FLAGS_DEFAULT;
    end else begin
      event_flags_status_q <= flags_d;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      parity_status_copy_q <= 1'b0;
      frame_status_copy_q  <= 1'b0;
      reset_status_copy_q  <= FLAGS_DEFAULT[FLAG_RESET];
    end else if (soft_reset_q) begin
      parity_status_copy_q <= 1'b0;
      frame_status_copy_q  <= 1'b0;
      reset_status_copy_q  <= FLAGS_DEFAULT[FLAG_RESET];
    end else begin
      parity_status_copy_q <= flags_d[FLAG_PARITY];
      frame_status_copy_q  <= flags_d[FLAG_FRAME];
      reset_status_copy_q  <= flags_d[FLAG_RESET];
    end
  end

  // read returns the value before the clear
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      read_data_q <= '0;
      read_done_q <= 1'b0;
    end else if (soft_reset_q) begin
      read_data_q <= '0;
      read_done_q <= 1'b0;
    end else begin
      read_done_q <= status_read;
      if (status_read) begin
        read_data_q <= event_flags_status_q;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cmd_word_q  <= '0;
      cmd_valid_q <= 1'b0;
    end else if (soft_reset_q) begin
      cmd_word_q  <= '0;
      cmd_valid_q <= 1'b0;
    end else begin
      cmd_valid_q <= frm.word_valid;
      if (frm.word_valid) begin
        cmd_word_q <= frm.word;
      end
    end
  end

endmodule

/* bench/sfcef_props.sv */
// port-level checker for the event flag block
module sfcef_props (
  input wire logic                            mclk,
  input wire logic                            resetn,
  input wire logic                            thermal_shutdown_pin,
  input wire logic [sfcef_pkg::SWITCH_NUM-1:0] switch_inputs,
  input wire logic [sfcef_pkg::REG_W-1:0]      event_flags_status_q,
  input wire logic [sfcef_pkg::REG_W-1:0]      read_data_q,
  input wire logic                            read_done_q,
  input wire logic [sfcef_pkg::FRAME_BITS-1:0] cmd_word_q,
  input wire logic                            cmd_valid_q,
  input wire logic                            parity_status_copy_q,
  input wire logic                            frame_status_copy_q,
  input wire logic                            reset_status_copy_q
);
  timeunit 1ns;
  timeprecision 1ps;
  import sfcef_pkg::*;
  wire logic [REG_W-1:0] f = event_flags_status_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  reset_default_a: assert property ($rose(resetn) |-> f == FLAGS_DEFAULT)
    else $error("flags not at default after reset");
  parity_copy_a: assert property (parity_status_copy_q == f[FLAG_PARITY])
    else $error("parity copy differs from flag");
  frame_copy_a: assert property (frame_status_copy_q == f[FLAG_FRAME])
    else $error("frame copy differs from flag");
  reset_copy_a: assert property (reset_status_copy_q == f[FLAG_RESET])
    else $error("reset copy differs from flag");
  reset_hold_a: assert property ($fell(f[FLAG_RESET]) |-> read_done_q)
    else $error("reset flag cleared without read");
  read_capture_a: assert property (read_done_q |-> read_data_q == $past(f))
    else $error("read data not the flags before clear");
  cmd_parity_a: assert property (cmd_valid_q |-> ^cmd_word_q)
    else $error("even parity word accepted");
  cmd_pulse_a: assert property (cmd_valid_q |=> !cmd_valid_q)
    else $error("accept pulse longer than one cycle");
  good_len_a: assert property (cmd_valid_q |-> !$rose(f[FLAG_FRAME]))
    else $error("frame flag on accepted word");
  therm_set_a: assert property ($changed(thermal_shutdown_pin) |-> ##4 f[FLAG_THERM])
    else $error("thermal flag not set");
  switch_set_a: assert property ($changed(switch_inputs) |-> ##[4:5] f[FLAG_SWITCH])
    else $error("switch flag not set");

  cover property (read_done_q);
  cover property (cmd_valid_q);
  cover property ($rose(f[FLAG_FRAME]));
  cover property ($rose(f[FLAG_PARITY]));
endmodule

/* bench/sfcef_spi_master.sv */
// serial master model shifting frames into the block
module sfcef_spi_master (
  output logic cs_n,
  output logic sclk,
  output logic sdi
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi  = 1'b0;
  end
  task automatic xfer(input logic [31:0] w, input int n);
    int i;
    cs_n = 1'b0;
    #100;
    for (i = 0; i < n; i++) begin
      sdi = w[31-(i%32)];
      #40 sclk = 1'b1;
      #40 sclk = 1'b0;
    end
    #100 cs_n = 1'b1;
    // stale data must not look valid
    sdi = ~sdi;
    #200;
  endtask
endmodule

/* bench/tb_serial_frame_check_event_flags.sv */
// self-checking bench for the event flag block
module tb_serial_frame_check_event_flags;
  timeunit 1ns;
  timeprecision 1ps;
  import sfcef_pkg::*;
  logic        mclk = 0, resetn = 0, thr = 0, ptrig = 0, pdone = 0;
  logic [23:0] sw, flags, rdat, last_rd;
  logic [31:0] cword, last_cmd, w;
  logic        rdone, cvalid, pcopy, fcopy, rcopy;
  wire         cs_n, sclk, sdi;
  int          n_cmd, n_mismatch, samples_checked, k0, seed = 1;
  int          lens[4] = '{0, 31, 33, 1};

  always #5 mclk = ~mclk;
  sfcef_spi_master i_mst (.cs_n(cs_n), .sclk(sclk), .sdi(sdi));
  sfcef_event_flags i_dut (.mclk(mclk), .resetn(resetn), .cs_n_pin(cs_n), .sclk_pin(sclk),
    .sdi_pin(sdi), .thermal_shutdown_pin(thr), .switch_inputs(sw), .polling_trigger(ptrig),
    .poll_cycle_done(pdone), .event_flags_status_q(flags), .read_data_q(rdat),
    .read_done_q(rdone), .cmd_word_q(cword), .cmd_valid_q(cvalid),
    .parity_status_copy_q(pcopy), .frame_status_copy_q(fcopy), .reset_status_copy_q(rcopy));

  always @(posedge mclk) begin
    if (rdone) last_rd <= rdat;
    if (cvalid) begin
      last_cmd <= cword;
      n_cmd <= n_cmd + 1;
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  function logic [31:0] mk(input logic wr, input logic [5:0] a, input logic [23:0] d);
    mk = {wr, a, d, 1'b0};
    mk[0] = ~^mk[31:1];
  endfunction
  task cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic pulse(ref logic s);
    @(negedge mclk) s = 1'b1;
    @(negedge mclk) s = 1'b0;
  endtask
  task rd(input logic [23:0] e);
    i_mst.xfer(mk(1'b0, ADR_EVENT_FLAGS, 24'($random(seed))), 32);
    chk(last_rd, e);
    chk(flags, 0);
    chk({pcopy, fcopy, rcopy}, 0);
  endtask
  task complete_run;
    $display("mismatches %0d of %0d checks", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #300_000;
    n_mismatch++;
    complete_run;
  end

  initial begin
    sw = 24'($random(seed));
    cyc(16);
    resetn = 1;
    cyc(4);
    chk(flags, FLAGS_DEFAULT);
    chk(rcopy, 1);
    rd(FLAGS_DEFAULT);
    chk(last_cmd[31:25], {1'b0, ADR_EVENT_FLAGS});
    foreach (lens[k]) begin
      k0 = n_cmd;
      i_mst.xfer(mk(1'b1, 6'h10, 24'($random(seed))), lens[k]);
      chk(flags, lens[k] ? 2 : 0);
      chk(fcopy, lens[k] != 0);
      chk(n_cmd, k0);
      rd(lens[k] ? 2 : 0);
    end
    // bad parity on a soft reset word: must not reset
    i_mst.xfer(mk(1'b1, ADR_CONTROL, 24'h00_0001) ^ 1, 32);
    chk(flags, 4);
    chk(pcopy, 1);
    rd(4);
    repeat (4) begin
      w = mk(1'b1, 6'h20 | 6'($random(seed)), 24'($random(seed)));
      i_mst.xfer(w, 32);
      chk(last_cmd, w);
      chk(flags, 0);
    end
    @(negedge mclk) thr = 1;
    cyc(8);
    chk(flags, 16);
    rd(16);
    @(negedge mclk) thr = 0;
    cyc(8);
    chk(flags, 16);
    rd(16);
    @(negedge mclk) sw = sw ^ (24'h1 << ($unsigned($random(seed)) % 24));
    cyc(8);
    chk(flags, 8);
    rd(8);
    pulse(ptrig);
    cyc(3);
    pulse(pdone);
    cyc(3);
    chk(flags, 8);
    rd(8);
    pulse(pdone);
    cyc(3);
    chk(flags, 0);
    i_mst.xfer(w, 31);
    i_mst.xfer(mk(1'b1, ADR_CONTROL, 24'h00_0001), 32);
    chk(flags, FLAGS_DEFAULT);
    chk(cword, 0);
    rd(FLAGS_DEFAULT);
    i_mst.xfer(w, 5);
    resetn = 0;
    cyc(2);
    resetn = 1;
    cyc(4);
    chk(flags, FLAGS_DEFAULT);
    complete_run;
  end
endmodule

bind sfcef_event_flags sfcef_props i_props (.mclk, .resetn, .thermal_shutdown_pin, .switch_inputs,
  .event_flags_status_q, .read_data_q, .read_done_q, .cmd_word_q, .cmd_valid_q,
  .parity_status_copy_q, .frame_status_copy_q, .reset_status_copy_q);
